// ===== logic/bsow_cfg.svh
`ifndef BSOW_CFG_SVH
`define BSOW_CFG_SVH
// comparison select codes
`define BSOW_SEL_SENSE_WIRE   3'h2
`define BSOW_SEL_BALANCE_WIRE 3'h3
`define BSOW_SEL_SWITCH       3'h4
// channel count and result layout
`define BSOW_NUM_CH           16
`define BSOW_CH_W             4
`define BSOW_HALF_W           8
`define BSOW_DATA_W           16
`define BSOW_RESULT_ABORT     8'hff
`define BSOW_AUX_DEFAULT      16'h8000
// aux channel select: 0 rotates over all, 1..16 locks one channel
`define BSOW_AUX_ALL          5'h00
`define BSOW_AUX_LOCK_MAX     5'h10
// switch count limits for a switch check
`define BSOW_MAX_SWITCHES     5'h08
// open wire threshold step in reading units per threshold code
`define BSOW_OW_STEP          16'h0100
`endif

// ===== logic/bsow_pkg.sv
package bsow_pkg;
  typedef enum logic [2:0] {
    BSOW_IDLE,
    BSOW_SCAN,
    BSOW_WAIT,
    BSOW_DONE
  } bsow_state_t;

  typedef enum logic [1:0] {
    BSOW_MODE_SWITCH,
    BSOW_MODE_SENSE,
    BSOW_MODE_BALANCE
  } bsow_mode_t;

  // one converter sample pair for a channel
  typedef struct packed {
    logic [3:0]  channel;
    logic [15:0] main_cell_reading;
    logic [15:0] aux_cell_reading;
  } bsow_sample_t;

  typedef struct packed {
    logic comparison_abort;
    logic aux_cell_ready;
    logic switch_check_ready;
    logic sense_wire_check_ready;
    logic balance_wire_check_ready;
  } bsow_flags_t;
endpackage : bsow_pkg

// ===== logic/bsow_top.sv
`timescale 1ns/1ps
`include "bsow_cfg.svh"
// How it works
// - code 0b100 plus go starts switch check
// - enabled switches: aux below half main
// - switch ready flag, results in two registers
// - cleared selects plus switch go opens switches
// - pause release restores configured balancing switches
// - refused check: abort, ready flags, results ff
// - locked aux selection aborted pulses reload output
// - refuse bad aux select or channel above count
// - refuse unless both converters run continuously
// - refuse while balancing runs unpaused
// - refuse over eight switches or three adjacent
// - test sinks on all pins per control bit
// - codes 0b010/0b011 plus go start wire checks
// - wire check compares readings to threshold
// - wire ready flag and matching result register
// - locked balance-wire reading copied to diag aux
// - sense-wire reading never copied to diag main
module bsow_top #(
  parameter logic [15:0] OW_STEP = `BSOW_OW_STEP
) (
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        clk_en_in,
  input  wire logic [2:0]                  comparison_select_in,
  input  wire logic                        comparison_go_in,
  input  wire logic                        switch_control_go_in,
  input  wire logic [7:0]                  diag_switch_select_a_in,
  input  wire logic [7:0]                  diag_switch_select_b_in,
  input  wire logic                        balancing_pause_in,
  input  wire logic                        balancing_active_in,
  input  wire logic [15:0]                 balance_config_in,
  input  wire logic                        main_adc_continuous_in,
  input  wire logic                        aux_adc_continuous_in,
  input  wire logic [4:0]                  aux_channel_select_in,
  input  wire logic [4:0]                  num_cell_in,
  input  wire logic [1:0]                  open_wire_sink_control_in,
  input  wire logic [3:0]                  open_wire_threshold_in,
  input  wire logic                        flags_clear_in,
  input  wire logic                        sample_valid_in,
  input  wire bsow_pkg::bsow_sample_t      sample_in,
  output logic [15:0]                      balance_switch_out,
  output logic [15:0]                      sense_sink_en_out,
  output logic [15:0]                      balance_sink_en_out,
  output logic [3:0]                       channel_req_out,
  output logic                             busy_out,
  output bsow_pkg::bsow_flags_t            flags_out,
  output logic [7:0]                       switch_result_a_out,
  output logic [7:0]                       switch_result_b_out,
  output logic [15:0]                      sense_wire_result_out,
  output logic [15:0]                      balance_wire_result_out,
  output logic [15:0]                      diag_aux_result_out,
  output logic                             aux_result_reload_out
);

  // ==========================================================
  // helper functions
  // ==========================================================
  function automatic logic [4:0] count_ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < `BSOW_NUM_CH; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction : count_ones

  function automatic logic three_adjacent(input logic [15:0] v);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `BSOW_NUM_CH - 2; i++) begin
      hit = hit | (v[i] & v[i+1] & v[i+2]);
    end
    return hit;
  endfunction : three_adjacent

  // ==========================================================
  // state
  // ==========================================================
  bsow_pkg::bsow_state_t state_reg, state_next;
  bsow_pkg::bsow_mode_t  mode_reg, mode_next;
  bsow_pkg::bsow_flags_t flags_reg, flags_next;
  logic                  go_pend_reg, go_pend_next;
  logic [3:0]            ch_reg, ch_next;
  logic [15:0]           sw_reg, sw_next;
  logic                  test_reg, test_next;
  logic                  pause_d_reg, pause_d_next;
  logic [15:0]           scan_mask_reg, scan_mask_next;
  logic [15:0]           res_reg, res_next;
  logic [7:0]            res_a_reg, res_a_next;
  logic [7:0]            res_b_reg, res_b_next;
  logic [15:0]           vcow_reg, vcow_next;
  logic [15:0]           cbow_reg, cbow_next;
  logic [15:0]           diag_aux_reg, diag_aux_next;
  logic                  reload_reg, reload_next;
  logic [15:0]           sense_sink_reg, sense_sink_next;
  logic [15:0]           bal_sink_reg, bal_sink_next;
  logic                  busy_reg, busy_next;

  // ==========================================================
  // start qualification
  // ==========================================================
  logic [15:0] diag_sel;
  logic        aux_locked;
  logic        aux_invalid;
  logic [3:0]  aux_lock_ch;
  logic        refuse;
  logic [15:0] aux_mask;
  logic [15:0] cell_mask;
  logic [15:0] ow_limit;

  always_comb begin
    diag_sel    = {diag_switch_select_b_in, diag_switch_select_a_in};
    aux_locked  = (aux_channel_select_in != `BSOW_AUX_ALL) &&
                  (aux_channel_select_in <= `BSOW_AUX_LOCK_MAX);
    aux_invalid = aux_channel_select_in > `BSOW_AUX_LOCK_MAX;
    aux_lock_ch = aux_channel_select_in[3:0] - 4'h1;
    cell_mask   = 16'h0000;
    for (int i = 0; i < `BSOW_NUM_CH; i++) begin
      cell_mask[i] = (5'(i) < num_cell_in);
    end
    aux_mask = aux_locked ? (cell_mask & (16'h0001 << aux_lock_ch)) : cell_mask;
    refuse = aux_invalid
           || (aux_locked && (aux_channel_select_in > num_cell_in))
           || !main_adc_continuous_in || !aux_adc_continuous_in
           || (balancing_active_in && !balancing_pause_in)
           || (count_ones(diag_sel) > `BSOW_MAX_SWITCHES)
           || three_adjacent(diag_sel);
    ow_limit = 16'(OW_STEP * {12'h000, open_wire_threshold_in});
  end

  // ==========================================================
  // next state
  // ==========================================================
  logic fail;
  logic last_ch;

  always_comb begin
    state_next      = state_reg;
    mode_next       = mode_reg;
    flags_next      = flags_reg;
    go_pend_next    = go_pend_reg | comparison_go_in;
    ch_next         = ch_reg;
    sw_next         = sw_reg;
    test_next       = test_reg;
    pause_d_next    = balancing_pause_in;
    scan_mask_next  = scan_mask_reg;
    res_next        = res_reg;
    res_a_next      = res_a_reg;
    res_b_next      = res_b_reg;
    vcow_next       = vcow_reg;
    cbow_next       = cbow_reg;
    diag_aux_next   = diag_aux_reg;
    reload_next     = 1'b0;
    fail            = 1'b0;
    last_ch         = (ch_reg == 4'(`BSOW_NUM_CH - 1));

    // test current sinks on every pin while the sink control bit is set
    sense_sink_next = open_wire_sink_control_in[0] ? 16'hffff : 16'h0000;
    bal_sink_next   = open_wire_sink_control_in[1] ? 16'hffff : 16'h0000;

    if (flags_clear_in) begin
      flags_next = '0;
    end

    // switch drive: test selection overrides balancing until released
    if (switch_control_go_in) begin
      sw_next   = diag_sel;
      test_next = (diag_sel != 16'h0000);
    end else if (pause_d_reg && !balancing_pause_in) begin
      test_next = 1'b0;
      sw_next   = balancing_active_in ? balance_config_in : 16'h0000;
    end else if (!test_reg) begin
      sw_next = (balancing_active_in && !balancing_pause_in) ? balance_config_in
                                                             : 16'h0000;
    end

    case (state_reg)
      bsow_pkg::BSOW_IDLE: begin
        if (go_pend_reg) begin
          go_pend_next = comparison_go_in;
          ch_next      = 4'h0;
          res_next     = 16'h0000;
          if (comparison_select_in == `BSOW_SEL_SWITCH) begin
            if (refuse) begin
              flags_next.comparison_abort   = 1'b1;
              flags_next.aux_cell_ready     = 1'b1;
              flags_next.switch_check_ready = 1'b1;
              res_a_next  = `BSOW_RESULT_ABORT;
              res_b_next  = `BSOW_RESULT_ABORT;
              reload_next = aux_locked;
            end else begin
              mode_next      = bsow_pkg::BSOW_MODE_SWITCH;
              scan_mask_next = diag_sel & aux_mask;
              state_next     = bsow_pkg::BSOW_SCAN;
            end
          end else if (comparison_select_in == `BSOW_SEL_SENSE_WIRE) begin
            mode_next      = bsow_pkg::BSOW_MODE_SENSE;
            scan_mask_next = cell_mask;
            state_next     = bsow_pkg::BSOW_SCAN;
          end else if (comparison_select_in == `BSOW_SEL_BALANCE_WIRE) begin
            mode_next      = bsow_pkg::BSOW_MODE_BALANCE;
            scan_mask_next = aux_mask;
            state_next     = bsow_pkg::BSOW_SCAN;
          end
        end
      end
      bsow_pkg::BSOW_SCAN: begin
        // channels outside the mask are skipped and pass
        if (scan_mask_reg[ch_reg]) begin
          state_next = bsow_pkg::BSOW_WAIT;
        end else if (last_ch) begin
          state_next = bsow_pkg::BSOW_DONE;
        end else begin
          ch_next = ch_reg + 4'h1;
        end
      end
      bsow_pkg::BSOW_WAIT: begin
        // a stale sample of another channel is ignored, the scan waits
        if (sample_valid_in && (sample_in.channel == ch_reg)) begin
          case (mode_reg)
            bsow_pkg::BSOW_MODE_SWITCH: begin
              fail = !(sample_in.aux_cell_reading <
                       {1'b0, sample_in.main_cell_reading[15:1]});
            end
            bsow_pkg::BSOW_MODE_SENSE: begin
              fail = sample_in.main_cell_reading < ow_limit;
            end
            default: begin
              fail = sample_in.aux_cell_reading < ow_limit;
            end
          endcase
          res_next[ch_reg] = fail;
          // main reading of a sense-wire check is deliberately not kept
          if (aux_locked && (mode_reg != bsow_pkg::BSOW_MODE_SENSE)) begin
            diag_aux_next = sample_in.aux_cell_reading;
          end
          if (last_ch) begin
            state_next = bsow_pkg::BSOW_DONE;
          end else begin
            ch_next    = ch_reg + 4'h1;
            state_next = bsow_pkg::BSOW_SCAN;
          end
        end
      end
      bsow_pkg::BSOW_DONE: begin
        state_next = bsow_pkg::BSOW_IDLE;
        case (mode_reg)
          bsow_pkg::BSOW_MODE_SWITCH: begin
            res_a_next = res_reg[7:0];
            res_b_next = res_reg[15:8];
            flags_next.switch_check_ready = 1'b1;
          end
          bsow_pkg::BSOW_MODE_SENSE: begin
            vcow_next = res_reg;
            flags_next.sense_wire_check_ready = 1'b1;
          end
          default: begin
            cbow_next = res_reg;
            flags_next.balance_wire_check_ready = 1'b1;
          end
        endcase
      end
      default: begin
        state_next = bsow_pkg::BSOW_IDLE;
      end
    endcase
    busy_next = (state_next != bsow_pkg::BSOW_IDLE);
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg      <= bsow_pkg::BSOW_IDLE;
      mode_reg       <= bsow_pkg::BSOW_MODE_SWITCH;
      flags_reg      <= '0;
      go_pend_reg    <= 1'b0;
      ch_reg         <= 4'h0;
      sw_reg         <= 16'h0000;
      test_reg       <= 1'b0;
      pause_d_reg    <= 1'b0;
      scan_mask_reg  <= 16'h0000;
      res_reg        <= 16'h0000;
      res_a_reg      <= 8'h00;
      res_b_reg      <= 8'h00;
      vcow_reg       <= 16'h0000;
      cbow_reg       <= 16'h0000;
      diag_aux_reg   <= `BSOW_AUX_DEFAULT;
      reload_reg     <= 1'b0;
      sense_sink_reg <= 16'h0000;
      bal_sink_reg   <= 16'h0000;
      busy_reg       <= 1'b0;
    end else if (clk_en_in) begin
      state_reg      <= state_next;
      mode_reg       <= mode_next;
      flags_reg      <= flags_next;
      go_pend_reg    <= go_pend_next;
      ch_reg         <= ch_next;
      sw_reg         <= sw_next;
      test_reg       <= test_next;
      pause_d_reg    <= pause_d_next;
      scan_mask_reg  <= scan_mask_next;
      res_reg        <= res_next;
      res_a_reg      <= res_a_next;
      res_b_reg      <= res_b_next;
      vcow_reg       <= vcow_next;
      cbow_reg       <= cbow_next;
      diag_aux_reg   <= diag_aux_next;
      reload_reg     <= reload_next;
      sense_sink_reg <= sense_sink_next;
      bal_sink_reg   <= bal_sink_next;
      busy_reg       <= busy_next;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign balance_switch_out      = sw_reg;
  assign sense_sink_en_out       = sense_sink_reg;
  assign balance_sink_en_out     = bal_sink_reg;
  assign channel_req_out         = ch_reg;
  assign busy_out                = busy_reg;
  assign flags_out               = flags_reg;
  assign switch_result_a_out     = res_a_reg;
  assign switch_result_b_out     = res_b_reg;
  assign sense_wire_result_out   = vcow_reg;
  assign balance_wire_result_out = cbow_reg;
  assign diag_aux_result_out     = diag_aux_reg;
  assign aux_result_reload_out   = reload_reg;
endmodule : bsow_top

// ===== verif/bsow_conv_model.sv
`timescale 1ns/1ps
// ==========================================================
// converter pair model: answers the channel under test
module bsow_conv_model (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   busy_in,
  input  wire logic [3:0]             channel_req_in,
  input  wire logic                   slow_in,
  input  wire logic [15:0]            fail_mask_in,
  output logic                        sample_valid_out,
  output bsow_pkg::bsow_sample_t      sample_out
);
  logic [2:0] wait_reg;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_reg         <= 3'h0;
      sample_valid_out <= 1'b0;
      sample_out       <= '0;
    end else begin
      sample_valid_out <= 1'b0;
      // idle cycles show a toggling pattern, every other one the last good sample
      sample_out       <= ~sample_out;
      if (busy_in && wait_reg == 3'h0) begin
        sample_valid_out <= 1'b1;
        sample_out       <= {channel_req_in,
                             fail_mask_in[channel_req_in] ? 16'h0300 : 16'h1000,
                             fail_mask_in[channel_req_in] ? 16'h0300 : 16'h0600};
        wait_reg         <= slow_in ? 3'h5 : 3'h0;
      end else if (busy_in) begin
        wait_reg <= wait_reg - 3'h1;
      end
    end
  end
endmodule : bsow_conv_model

// ===== verif/bsow_top_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module bsow_top_asserts (
  input wire logic                  mclk_in,
  input wire logic                  rst_n_in,
  input wire logic                  clk_en_in,
  input wire logic [2:0]            comparison_select_in,
  input wire logic                  comparison_go_in,
  input wire logic                  switch_control_go_in,
  input wire logic [7:0]            diag_switch_select_a_in,
  input wire logic [7:0]            diag_switch_select_b_in,
  input wire logic                  balancing_pause_in,
  input wire logic                  balancing_active_in,
  input wire logic                  main_adc_continuous_in,
  input wire logic                  aux_adc_continuous_in,
  input wire logic [1:0]            open_wire_sink_control_in,
  input wire logic                  flags_clear_in,
  input wire logic [15:0]           balance_switch_out,
  input wire logic [15:0]           sense_sink_en_out,
  input wire logic                  busy_out,
  input wire bsow_pkg::bsow_flags_t flags_out,
  input wire logic [7:0]            switch_result_a_out,
  input wire logic [7:0]            switch_result_b_out,
  input wire logic                  aux_result_reload_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_sw_go;
    comparison_go_in && comparison_select_in == 3'h4 && !busy_out;
  endsequence
  sequence s_reload;
    aux_result_reload_out ##1 !aux_result_reload_out;
  endsequence
  a_switch_go_load: assert property (
    clk_en_in && switch_control_go_in && balancing_pause_in |=>
    balance_switch_out == $past({diag_switch_select_b_in, diag_switch_select_a_in}))
    else $error("switch outputs not loaded");
  a_abort_results: assert property (
    $rose(flags_out.comparison_abort) |-> switch_result_a_out == 8'hff &&
    switch_result_b_out == 8'hff && flags_out.switch_check_ready && flags_out.aux_cell_ready)
    else $error("abort without forced results");
  a_abort_switch_only: assert property (
    $rose(flags_out.comparison_abort) |-> comparison_select_in == 3'h4)
    else $error("wire check aborted");
  a_refuse_converter: assert property (
    s_sw_go ##0 !(main_adc_continuous_in && aux_adc_continuous_in)
    |-> ##[1:3] flags_out.comparison_abort) else $error("converter off not refused");
  a_refuse_balancing: assert property (
    s_sw_go ##0 (balancing_active_in && !balancing_pause_in)
    |-> ##[1:3] flags_out.comparison_abort) else $error("active balancing not refused");
  a_refuse_count: assert property (
    s_sw_go ##0 ($countones({diag_switch_select_b_in, diag_switch_select_a_in}) > 8)
    |-> ##[1:3] flags_out.comparison_abort) else $error("too many switches not refused");
  a_reload_abort: assert property (
    aux_result_reload_out |-> s_reload ##0 flags_out.comparison_abort)
    else $error("reload without abort");
  a_sense_sink: assert property (
    $past(clk_en_in) |-> sense_sink_en_out == {16{$past(open_wire_sink_control_in[0])}})
    else $error("sense sinks wrong");
  a_ready_sticky: assert property (
    flags_out.switch_check_ready && !flags_clear_in |=> flags_out.switch_check_ready)
    else $error("switch ready dropped");
  a_wire_sticky: assert property (
    flags_out.sense_wire_check_ready && !flags_clear_in |=> flags_out.sense_wire_check_ready)
    else $error("sense ready dropped");
endmodule : bsow_top_asserts
bind bsow_top bsow_top_asserts bsow_top_asserts_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .clk_en_in(clk_en_in),
  .comparison_select_in(comparison_select_in), .comparison_go_in(comparison_go_in),
  .switch_control_go_in(switch_control_go_in),
  .diag_switch_select_a_in(diag_switch_select_a_in),
  .diag_switch_select_b_in(diag_switch_select_b_in),
  .balancing_pause_in(balancing_pause_in), .balancing_active_in(balancing_active_in),
  .main_adc_continuous_in(main_adc_continuous_in),
  .aux_adc_continuous_in(aux_adc_continuous_in),
  .open_wire_sink_control_in(open_wire_sink_control_in), .flags_clear_in(flags_clear_in),
  .balance_switch_out(balance_switch_out), .sense_sink_en_out(sense_sink_en_out),
  .busy_out(busy_out), .flags_out(flags_out), .switch_result_a_out(switch_result_a_out),
  .switch_result_b_out(switch_result_b_out), .aux_result_reload_out(aux_result_reload_out));

// ===== verif/bsow_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module bsow_top_tb_top;
  logic mclk_in = 0, rst_n_in = 0, go = 0, sw_go = 0, pause = 1, active = 1;
  logic main_c = 1, aux_c = 1, fclr = 0, sv, slow = 0, reload, busy, rl_seen = 0, cen = 1;
  logic [2:0]  sel = 3'h0;
  logic [7:0]  sel_a = 8'h00, sel_b = 8'h00, res_a, res_b;
  logic [4:0]  aux_sel = 5'h00, num_cell = 5'h10;
  logic [1:0]  sink = 2'h0;
  logic [3:0]  thr = 4'h4, ch_req;
  logic [15:0] cfg = 16'h00f0, fmask = 16'h0000, sw_out, snk_s, snk_b, res_sw, res_bw, diag;
  int          mismatches = 0, cmp_count = 0;
  bsow_pkg::bsow_sample_t smp;
  bsow_pkg::bsow_flags_t  flags;
  bsow_top bsow_top_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clk_en_in(cen),
    .comparison_select_in(sel), .comparison_go_in(go), .switch_control_go_in(sw_go),
    .diag_switch_select_a_in(sel_a), .diag_switch_select_b_in(sel_b),
    .balancing_pause_in(pause), .balancing_active_in(active), .balance_config_in(cfg),
    .main_adc_continuous_in(main_c), .aux_adc_continuous_in(aux_c),
    .aux_channel_select_in(aux_sel), .num_cell_in(num_cell),
    .open_wire_sink_control_in(sink), .open_wire_threshold_in(thr), .flags_clear_in(fclr),
    .sample_valid_in(sv), .sample_in(smp), .balance_switch_out(sw_out),
    .sense_sink_en_out(snk_s), .balance_sink_en_out(snk_b), .channel_req_out(ch_req),
    .busy_out(busy), .flags_out(flags), .switch_result_a_out(res_a),
    .switch_result_b_out(res_b), .sense_wire_result_out(res_sw),
    .balance_wire_result_out(res_bw), .diag_aux_result_out(diag),
    .aux_result_reload_out(reload));
  bsow_conv_model bsow_conv_model_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .busy_in(busy),
    .channel_req_in(ch_req), .slow_in(slow), .fail_mask_in(fmask),
    .sample_valid_out(sv), .sample_out(smp));
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) if (reload === 1'b1) rl_seen <= 1'b1;
  // ==========================================================
  // shared steps
  task automatic pulse(ref logic s);
    @(negedge mclk_in);
    s = 1'b1;
    @(negedge mclk_in);
    s = 1'b0;
  endtask : pulse
  task automatic run_cmp(input logic [2:0] code);
    int n;
    n = 0;
    pulse(fclr);
    sel = code;
    pulse(go);
    repeat (3) @(negedge mclk_in);
    while (busy === 1'b1 && n < 2000) begin
      @(negedge mclk_in);
      n++;
    end
    `CHK("busy", 1'b0, busy)
    repeat (2) @(negedge mclk_in);
  endtask : run_cmp
  // ==========================================================
  // scenarios
  task automatic t_switch_ctrl();
    sel_a = 8'h05;
    sel_b = 8'h80;
    pulse(sw_go);
    `CHK("switch_on", 16'h8005, sw_out)
    sel_a = 8'h00;
    sel_b = 8'h00;
    pulse(sw_go);
    `CHK("switch_off", 16'h0000, sw_out)
  endtask : t_switch_ctrl
  task automatic t_freeze();
    // a go strobe while the enable is low must leave the switches untouched
    sel_a = 8'h01;
    cen = 1'b0;
    pulse(sw_go);
    repeat (2) @(negedge mclk_in);
    `CHK("frozen", 16'h0000, sw_out)
    cen = 1'b1;
    sel_a = 8'h00;
    repeat (2) @(negedge mclk_in);
    `CHK("thawed", 16'h0000, sw_out)
  endtask : t_freeze
  task automatic t_switch_check();
    fmask = 16'h2403;
    slow = 1'b1;
    sel_a = 8'h66;
    sel_b = 8'h66;
    pulse(sw_go);
    run_cmp(3'h4);
    `CHK("sw_result", 16'h2402, {res_b, res_a})
    `CHK("sw_ready", 1'b1, flags.switch_check_ready)
    `CHK("sw_abort", 1'b0, flags.comparison_abort)
    pause = 1'b0;
    repeat (2) @(negedge mclk_in);
    `CHK("resume", 16'h00f0, sw_out)
    pause = 1'b1;
    slow = 1'b0;
  endtask : t_switch_check
  task automatic t_open_wire();
    fmask = 16'h8011;
    num_cell = 5'h0c;
    sink = 2'b01;
    repeat (2) @(negedge mclk_in);
    `CHK("sense_sinks", 16'hffff, snk_s)
    `CHK("bal_sinks", 16'h0000, snk_b)
    run_cmp(3'h2);
    `CHK("sense_res", 16'h0011, res_sw)
    `CHK("sense_ready", 1'b1, flags.sense_wire_check_ready)
    `CHK("diag_main_kept", 16'h8000, diag)
    sink = 2'b10;
    aux_sel = 5'h05;
    run_cmp(3'h3);
    `CHK("bal_res", 16'h0010, res_bw)
    `CHK("bal_ready", 1'b1, flags.balance_wire_check_ready)
    `CHK("diag_aux", 16'h0300, diag)
    sink = 2'b00;
  endtask : t_open_wire
  task automatic t_refuse();
    for (int k = 0; k < 8; k++) begin
      @(negedge mclk_in);
      {main_c, aux_c, pause, aux_sel, num_cell} = {3'b111, 5'h00, 5'h0c};
      {sel_b, sel_a} = 16'h0066;
      case (k)
        0: aux_sel = 5'h11;
        1: aux_sel = 5'h0d;
        2: main_c = 1'b0;
        3: aux_c = 1'b0;
        4: pause = 1'b0;
        5: {sel_b, sel_a} = 16'h16db;
        6: sel_a = 8'h07;
        default: aux_sel = 5'h0c;
      endcase
      rl_seen = 1'b0;
      run_cmp(3'h4);
      `CHK("abort", k < 7, flags.comparison_abort)
      `CHK("sw_ready", 1'b1, flags.switch_check_ready)
      if (k < 7) `CHK("ff_result", 16'hffff, {res_b, res_a})
      if (k < 7) `CHK("aux_ready", 1'b1, flags.aux_cell_ready)
      `CHK("reload", k == 1, rl_seen)
    end
  endtask : t_refuse
  // ==========================================================
  // verdict
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    // well beyond the few hundred cycles the scenarios need
    #200000;
    mismatches++;
    $display("MISMATCH watchdog exp done got hang");
    report_and_stop();
  end
  initial begin
    repeat (12) @(negedge mclk_in);
    rst_n_in = 1'b1;
    t_switch_ctrl();
    t_freeze();
    t_switch_check();
    t_open_wire();
    t_refuse();
    report_and_stop();
  end
endmodule : bsow_top_tb_top
